// [pkg/usat_consts.svh]
// Register offsets, field positions, reset values and timing counts of the serial transceiver.
`ifndef USAT_CONSTS_SVH
`define USAT_CONSTS_SVH
`define USAT_OFS_IRQ_FLAGS 8'h0c
`define USAT_OFS_RX_CTRL 8'h18
`define USAT_OFS_TX_HOLD 8'h19
`define USAT_OFS_RX_HOLD 8'h1a
`define USAT_OFS_IRQ_EN 8'h8c
`define USAT_OFS_TX_CTRL 8'h98
`define USAT_OFS_BAUD 8'h99
`define USAT_RX_ON_BIT 7
`define USAT_RX9_BIT 6
`define USAT_SINGLE_RX_ON_BIT 5
`define USAT_CONTINUOUS_RX_ON_BIT 4
`define USAT_FRAME_ERR_FLAG_BIT 2
`define USAT_OVERRUN_ERR_FLAG_BIT 1
`define USAT_RX_NINTH_BIT_BIT 0
`define USAT_CLOCK_SOURCE_MASTER_BIT 7
`define USAT_TX9_BIT 6
`define USAT_TX_ON_BIT 5
`define USAT_SYNC_BIT 4
`define USAT_HIGH_BAUD_SEL_BIT 2
`define USAT_SHIFTER_EMPTY_STATUS_BIT 1
`define USAT_TX_NINTH_BIT_BIT 0
`define USAT_RX_FULL_FLAG_BIT 5
`define USAT_TX_BUFFER_EMPTY_FLAG_BIT 4
`define USAT_TX_CTRL_RST 8'h02
`define USAT_BYTE_RST 8'h00
`define USAT_LOW_OVS 16
`define USAT_HIGH_OVS 4
`endif

// [pkg/usat_pkg.sv]
// Types shared by the serial transceiver modules.
package usat_pkg;
  typedef enum logic [1:0] {
    USAT_IDLE = 2'b00,
    USAT_START = 2'b01,
    USAT_DATA = 2'b11,
    USAT_STOP = 2'b10
  } usat_phase_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usat_bus_type;

  typedef struct packed {
    usat_phase_type phase;
    logic [5:0] os_cnt;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic line;
  } usat_tx_type;

  typedef struct packed {
    usat_phase_type phase;
    logic [5:0] os_cnt;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic stop_bad;
  } usat_rx_type;

  typedef struct packed {
    logic [7:0] baud_cnt;
    logic tick;
  } usat_baud_type;
endpackage

// [verilog/usat_baud.sv]
// Baud divider producing one-cycle oversample tick enables.
`timescale 1ns/1ps
module usat_baud (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [7:0] divisor,
  output logic tick
);
  usat_pkg::usat_baud_type st_r;
  usat_pkg::usat_baud_type st_nxt;

  // The tick period is divisor plus one cycles.
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.baud_cnt = 8'h00;
    end else if (st_r.baud_cnt >= divisor) begin
      st_nxt.baud_cnt = 8'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.baud_cnt = st_r.baud_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule // usat_baud

// [verilog/usat_core.sv]
// Asynchronous serial transceiver with receive status and transmit path.
`include "usat_consts.svh"
`timescale 1ns/1ps
// Overview of operation
// - Receive nine-bit select chooses nine or eight captured data bits.
// - A bad stop bit sets framing error, refreshed with each word moved to receive holding.
// - Overrun sets overrun error; clearing continuous receive enable clears it.
// - Ninth received bit appears in bit 0 of receive status.
// - Setting transmit enable sets the transmit buffer empty flag when the holding register is empty.
// - Writing transmit holding starts transmission once transmit and the serial port (receive control bit 7) are both enabled.
// - Transmit status resets to 0x02 with shifter empty reading one.
// - Unimplemented bits, such as bit 3, read as zero.
// - Empty shifter loads next held word and sets buffer empty flag; a word written to transmit holding in the load cycle leaves the flag clear.
// - Completed word moves to receive holding and raises receive full; if receive full is still set, the word is dropped and overrun is set.
module usat_core (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic irq
);
  typedef struct packed {
    logic [7:0] rx_ctrl;
    logic [7:0] tx_ctrl;
    logic [7:0] baud;
    logic [7:0] irq_en;
    logic [7:0] tx_hold;
    logic tx_hold_full;
    logic tx_buffer_empty_flag;
    logic rx_full_flag;
    logic [7:0] rx_hold;
    logic rx_hold_9;
    logic rx_hold_frame_err_flag;
    usat_pkg::usat_tx_type tx;
    usat_pkg::usat_rx_type rx;
    logic [1:0] rx_sync;
    logic [7:0] rdata;
    logic irq;
  } usat_state_type;

  usat_state_type st_r;
  usat_state_type st_nxt;
  usat_pkg::usat_bus_type bus;
  logic tick;
  logic [5:0] os_len;
  logic rx_in;
  logic sp_on;
  logic hold_wr;

  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
  assign sp_on = st_r.rx_ctrl[`USAT_RX_ON_BIT];
  assign hold_wr = bus.wr && (bus.addr == `USAT_OFS_TX_HOLD);
  assign rx_in = st_r.rx_sync[1];
  assign os_len = st_r.tx_ctrl[`USAT_HIGH_BAUD_SEL_BIT] ? 6'(`USAT_HIGH_OVS) : 6'(`USAT_LOW_OVS);

  usat_baud u_baud (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(sp_on),
    .divisor(st_r.baud),
    .tick(tick)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_sync = {st_r.rx_sync[0], rx_pin};
    // Register writes.
    if (bus.wr) begin
      case (bus.addr)
        `USAT_OFS_RX_CTRL: begin
          st_nxt.rx_ctrl[7:4] = bus.wdata[7:4];
          if (!bus.wdata[`USAT_CONTINUOUS_RX_ON_BIT]) begin
            st_nxt.rx_ctrl[`USAT_OVERRUN_ERR_FLAG_BIT] = 1'b0;
          end
        end
        `USAT_OFS_TX_CTRL: begin
          st_nxt.tx_ctrl = {bus.wdata[7:4], 1'b0, bus.wdata[2], st_r.tx_ctrl[1], bus.wdata[0]};
          if (bus.wdata[`USAT_TX_ON_BIT] && !st_r.tx_ctrl[`USAT_TX_ON_BIT]) begin
            st_nxt.tx_buffer_empty_flag = !st_r.tx_hold_full;
          end
        end
        `USAT_OFS_TX_HOLD: begin
          st_nxt.tx_hold = bus.wdata;
          st_nxt.tx_hold_full = 1'b1;
          st_nxt.tx_buffer_empty_flag = 1'b0;
        end
        `USAT_OFS_BAUD: st_nxt.baud = bus.wdata;
        `USAT_OFS_IRQ_EN: st_nxt.irq_en = bus.wdata & 8'h30;
        default: ;
      endcase
    end
    // Reads; reading receive holding releases it and clears receive full.
    st_nxt.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `USAT_OFS_IRQ_FLAGS: st_nxt.rdata = {2'b00, st_r.rx_full_flag, st_r.tx_buffer_empty_flag, 4'h0};
        `USAT_OFS_RX_CTRL: st_nxt.rdata = {st_r.rx_ctrl[7:4], 1'b0, st_r.rx_ctrl[2:0]};
        `USAT_OFS_RX_HOLD: begin
          st_nxt.rdata = st_r.rx_hold;
          st_nxt.rx_full_flag = 1'b0;
        end
        `USAT_OFS_IRQ_EN: st_nxt.rdata = st_r.irq_en;
        `USAT_OFS_TX_CTRL: st_nxt.rdata = st_r.tx_ctrl;
        `USAT_OFS_BAUD: st_nxt.rdata = st_r.baud;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // Transmit shifter.
    if (!sp_on || !st_r.tx_ctrl[`USAT_TX_ON_BIT]) begin
      st_nxt.tx.phase = usat_pkg::USAT_IDLE;
      st_nxt.tx.line = 1'b1;
    end else if (st_r.tx.phase == usat_pkg::USAT_IDLE) begin
      st_nxt.tx_ctrl[`USAT_SHIFTER_EMPTY_STATUS_BIT] = !st_r.tx_hold_full;
      if (st_r.tx_hold_full && tick) begin
        st_nxt.tx.shift = {st_r.tx_ctrl[`USAT_TX_NINTH_BIT_BIT], st_r.tx_hold};
        // A word written in the load cycle refills the holding register, so it stays full.
        st_nxt.tx_hold_full = hold_wr;
        st_nxt.tx_buffer_empty_flag = !hold_wr;
        st_nxt.tx.phase = usat_pkg::USAT_START;
        st_nxt.tx.os_cnt = 6'd0;
        st_nxt.tx.bit_cnt = 4'd0;
        st_nxt.tx.line = 1'b0;
        st_nxt.tx_ctrl[`USAT_SHIFTER_EMPTY_STATUS_BIT] = 1'b0;
      end
    end else if (tick) begin
      st_nxt.tx.os_cnt = st_r.tx.os_cnt + 6'd1;
      if (st_r.tx.os_cnt == os_len - 6'd1) begin
        st_nxt.tx.os_cnt = 6'd0;
        case (st_r.tx.phase)
          usat_pkg::USAT_START, usat_pkg::USAT_DATA: begin
            if (st_r.tx.phase == usat_pkg::USAT_DATA &&
                st_r.tx.bit_cnt == (st_r.tx_ctrl[`USAT_TX9_BIT] ? 4'd9 : 4'd8)) begin
              st_nxt.tx.phase = usat_pkg::USAT_STOP;
              st_nxt.tx.line = 1'b1;
            end else begin
              st_nxt.tx.phase = usat_pkg::USAT_DATA;
              st_nxt.tx.line = st_r.tx.shift[0];
              st_nxt.tx.shift = {1'b0, st_r.tx.shift[8:1]};
              st_nxt.tx.bit_cnt = st_r.tx.bit_cnt + 4'd1;
            end
          end
          usat_pkg::USAT_STOP: st_nxt.tx.phase = usat_pkg::USAT_IDLE;
          default: st_nxt.tx.phase = usat_pkg::USAT_IDLE;
        endcase
      end
    end
    // Receiver runs only with continuous receive; single receive is ignored.
    if (!sp_on || !st_r.rx_ctrl[`USAT_CONTINUOUS_RX_ON_BIT]) begin
      st_nxt.rx.phase = usat_pkg::USAT_IDLE;
    end else if (tick) begin
      st_nxt.rx.os_cnt = st_r.rx.os_cnt + 6'd1;
      case (st_r.rx.phase)
        usat_pkg::USAT_IDLE: begin
          st_nxt.rx.os_cnt = 6'd0;
          st_nxt.rx.bit_cnt = 4'd0;
          if (!rx_in) begin
            st_nxt.rx.phase = usat_pkg::USAT_START;
          end
        end
        usat_pkg::USAT_START: begin
          if (st_r.rx.os_cnt == (os_len >> 1) - 6'd1) begin
            st_nxt.rx.os_cnt = 6'd0;
            st_nxt.rx.phase = rx_in ? usat_pkg::USAT_IDLE : usat_pkg::USAT_DATA;
          end
        end
        usat_pkg::USAT_DATA: begin
          if (st_r.rx.os_cnt == os_len - 6'd1) begin
            st_nxt.rx.os_cnt = 6'd0;
            st_nxt.rx.shift = {rx_in, st_r.rx.shift[8:1]};
            st_nxt.rx.bit_cnt = st_r.rx.bit_cnt + 4'd1;
            if (st_r.rx.bit_cnt == (st_r.rx_ctrl[`USAT_RX9_BIT] ? 4'd8 : 4'd7)) begin
              st_nxt.rx.phase = usat_pkg::USAT_STOP;
            end
          end
        end
        usat_pkg::USAT_STOP: begin
          if (st_r.rx.os_cnt == os_len - 6'd1) begin
            st_nxt.rx.phase = usat_pkg::USAT_IDLE;
            if (st_r.rx_full_flag && !(bus.rd && bus.addr == `USAT_OFS_RX_HOLD)) begin
              st_nxt.rx_ctrl[`USAT_OVERRUN_ERR_FLAG_BIT] = 1'b1;
            end else begin
              st_nxt.rx_hold = st_r.rx_ctrl[`USAT_RX9_BIT] ? st_r.rx.shift[7:0] : st_r.rx.shift[8:1];
              st_nxt.rx_ctrl[`USAT_RX_NINTH_BIT_BIT] = st_r.rx_ctrl[`USAT_RX9_BIT] & st_r.rx.shift[8];
              st_nxt.rx_ctrl[`USAT_FRAME_ERR_FLAG_BIT] = !rx_in;
              st_nxt.rx_full_flag = 1'b1;
            end
          end
        end
        default: st_nxt.rx.phase = usat_pkg::USAT_IDLE;
      endcase
    end
    st_nxt.irq = (st_nxt.rx_full_flag & st_nxt.irq_en[`USAT_RX_FULL_FLAG_BIT]) | (st_nxt.tx_buffer_empty_flag & st_nxt.irq_en[`USAT_TX_BUFFER_EMPTY_FLAG_BIT]);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.tx_ctrl <= `USAT_TX_CTRL_RST;
      st_r.tx.line <= 1'b1;
      st_r.rx_sync <= 2'b11;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata = st_r.rdata;
  assign tx_pin = st_r.tx.line;
  assign irq = st_r.irq;

  property p_tx_reset;
    @(posedge sys_clk) $rose(reset_n) |-> st_r.tx_ctrl == 8'h02;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("transmit status reset value wrong");

  property p_tx_on_sets_tx_buffer_empty_flag;
    @(posedge sys_clk) disable iff (!reset_n)
      bus_wr && bus_addr == 8'h98 && bus_wdata[5] && !st_r.tx_ctrl[5] && !st_r.tx_hold_full |=> st_r.tx_buffer_empty_flag;
  endproperty
  a_tx_on_sets_tx_buffer_empty_flag: assert property (p_tx_on_sets_tx_buffer_empty_flag) else $error("transmit enable did not set flag");

  property p_bit3_zero;
    @(posedge sys_clk) disable iff (!reset_n)
      bus_rd && (bus_addr == 8'h18 || bus_addr == 8'h98) |=> !bus_rdata[3];
  endproperty
  a_bit3_zero: assert property (p_bit3_zero) else $error("unimplemented bit read as one");

  property p_overrun_err_flag_clear;
    @(posedge sys_clk) disable iff (!reset_n)
      bus_wr && bus_addr == 8'h18 && !bus_wdata[4] |=> !st_r.rx_ctrl[1];
  endproperty
  a_overrun_err_flag_clear: assert property (p_overrun_err_flag_clear) else $error("overrun flag not cleared");

  property p_idle_high;
    @(posedge sys_clk) disable iff (!reset_n)
      st_r.tx.phase == usat_pkg::USAT_IDLE |-> tx_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");

  property p_load_sets_tx_buffer_empty_flag;
    @(posedge sys_clk) disable iff (!reset_n)
      st_r.tx.phase == usat_pkg::USAT_IDLE ##1 st_r.tx.phase == usat_pkg::USAT_START |-> st_r.tx_buffer_empty_flag || $past(bus_wr);
  endproperty
  a_load_sets_tx_buffer_empty_flag: assert property (p_load_sets_tx_buffer_empty_flag) else $error("load did not set empty flag");

  property p_rx_done;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(st_r.rx_full_flag) |-> st_r.rx.phase == usat_pkg::USAT_IDLE;
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive full raised mid frame");

  property p_no_rx_without_continuous_rx_on;
    @(posedge sys_clk) disable iff (!reset_n)
      !st_r.rx_ctrl[4] |=> st_r.rx.phase == usat_pkg::USAT_IDLE;
  endproperty
  a_no_rx_without_continuous_rx_on: assert property (p_no_rx_without_continuous_rx_on) else $error("receiver ran while disabled");

  property p_ninth_zero_8bit;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(st_r.rx_full_flag) && !st_r.rx_ctrl[6] |-> !st_r.rx_ctrl[0];
  endproperty
  a_ninth_zero_8bit: assert property (p_ninth_zero_8bit) else $error("ninth bit set in eight-bit mode");
endmodule // usat_core

// [sim/usat_remote.sv]
// Model of the remote serial partner on the transmit and receive pins.
`timescale 1ns/1ps
module usat_remote #(parameter int BIT_CYC = 8) (
  input wire logic sys_clk,
  input wire logic nine,
  input wire logic tx_line,
  output logic rx_line
);
  logic [8:0] got;
  logic got_stop;
  int n_got = 0;
  // Bit length in clock cycles; the bench changes it when it selects another rate.
  int bit_cyc = BIT_CYC;
  initial rx_line = 1'b1;
  // Sends low start, data LSB first, the given stop level, then idles high.
  task automatic send(input logic [8:0] d, input logic nb, input logic stop);
    @(posedge sys_clk);
    rx_line <= 1'b0;
    repeat (bit_cyc) @(posedge sys_clk);
    for (int i = 0; i < (nb ? 9 : 8); i++) begin
      rx_line <= d[i];
      repeat (bit_cyc) @(posedge sys_clk);
    end
    rx_line <= stop;
    repeat (bit_cyc) @(posedge sys_clk);
    rx_line <= 1'b1;
    repeat (bit_cyc) @(posedge sys_clk);
  endtask
  // Samples each bit in its middle after the falling start edge.
  always begin
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge sys_clk);
    got = 9'h000;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_cyc) @(posedge sys_clk);
      got[i] = tx_line;
    end
    repeat (bit_cyc) @(posedge sys_clk);
    got_stop = tx_line;
    n_got++;
  end
endmodule // usat_remote

// [sim/usart_async_tx_and_rx_status_test.sv]
// Self-checking bench for the transceiver registers and both serial directions.
`timescale 1ns/1ps
`include "usat_consts.svh"
module usart_async_tx_and_rx_status_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic rx_pin;
  logic tx_pin;
  logic irq;
  logic nine = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  always #10 sys_clk = ~sys_clk;
  usat_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
  usat_remote #(.BIT_CYC(8)) u_remote (.sys_clk(sys_clk), .nine(nine),
    .tx_line(tx_pin), .rx_line(rx_pin));
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {1'b0, exp}, {1'b0, bus_rdata});
  endtask
  task automatic wait_rx(input int n, input logic [8:0] exp);
    for (int k = 0; k < 400 && u_remote.n_got != n; k++) @(posedge sys_clk);
    chk("words seen", 9'(n), 9'(u_remote.n_got));
    chk("word seen on line", exp, u_remote.got);
    chk("stop level", 9'h001, {8'h00, u_remote.got_stop});
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`USAT_OFS_TX_CTRL, 8'h02);
    rd(`USAT_OFS_RX_CTRL, 8'h00);
    rd(`USAT_OFS_IRQ_FLAGS, 8'h00);
    rd(`USAT_OFS_IRQ_EN, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(`USAT_OFS_BAUD, 8'h01);
    rd(`USAT_OFS_BAUD, 8'h01);
    wr(`USAT_OFS_TX_CTRL, 8'h0c);
    rd(`USAT_OFS_TX_CTRL, 8'h06);
    $display("test registers done");
    wr(`USAT_OFS_RX_CTRL, 8'h80);
    wr(`USAT_OFS_IRQ_EN, 8'h10);
    wr(`USAT_OFS_TX_CTRL, 8'h24);
    rd(`USAT_OFS_IRQ_FLAGS, 8'h10);
    chk("irq", 9'h001, {8'h00, irq});
    wr(`USAT_OFS_TX_HOLD, 8'ha5);
    wr(`USAT_OFS_TX_HOLD, 8'h5c);
    rd(`USAT_OFS_IRQ_FLAGS, 8'h00);
    wait_rx(1, 9'h0a5);
    wait_rx(2, 9'h05c);
    repeat (16) @(posedge sys_clk);
    rd(`USAT_OFS_TX_CTRL, 8'h26);
    rd(`USAT_OFS_IRQ_FLAGS, 8'h10);
    nine = 1'b1;
    wr(`USAT_OFS_TX_CTRL, 8'h65);
    wr(`USAT_OFS_TX_HOLD, 8'h3c);
    wait_rx(3, 9'h13c);
    nine = 1'b0;
    u_remote.bit_cyc = 16;
    wr(`USAT_OFS_BAUD, 8'h00);
    wr(`USAT_OFS_TX_CTRL, 8'h20);
    wr(`USAT_OFS_TX_HOLD, 8'h96);
    wait_rx(4, 9'h096);
    u_remote.bit_cyc = 8;
    wr(`USAT_OFS_BAUD, 8'h01);
    wr(`USAT_OFS_TX_CTRL, 8'h24);
    wr(`USAT_OFS_IRQ_EN, 8'h00);
    rd(`USAT_OFS_IRQ_EN, 8'h00);
    chk("irq", 9'h000, {8'h00, irq});
    $display("test transmit done");
    wr(`USAT_OFS_IRQ_EN, 8'h20);
    wr(`USAT_OFS_RX_CTRL, 8'ha0);
    u_remote.send(9'h05a, 1'b0, 1'b1);
    rd(`USAT_OFS_IRQ_FLAGS, 8'h10);
    wr(`USAT_OFS_RX_CTRL, 8'h90);
    u_remote.send(9'h05a, 1'b0, 1'b1);
    rd(`USAT_OFS_IRQ_FLAGS, 8'h30);
    chk("irq", 9'h001, {8'h00, irq});
    rd(`USAT_OFS_RX_HOLD, 8'h5a);
    rd(`USAT_OFS_IRQ_FLAGS, 8'h10);
    chk("irq", 9'h000, {8'h00, irq});
    wr(`USAT_OFS_RX_CTRL, 8'hd0);
    u_remote.send(9'h1c3, 1'b1, 1'b1);
    rd(`USAT_OFS_RX_CTRL, 8'hd1);
    rd(`USAT_OFS_RX_HOLD, 8'hc3);
    wr(`USAT_OFS_RX_CTRL, 8'h90);
    u_remote.send(9'h033, 1'b0, 1'b0);
    rd(`USAT_OFS_RX_CTRL, 8'h94);
    rd(`USAT_OFS_RX_HOLD, 8'h33);
    u_remote.send(9'h044, 1'b0, 1'b1);
    rd(`USAT_OFS_RX_CTRL, 8'h90);
    u_remote.send(9'h011, 1'b0, 1'b1);
    rd(`USAT_OFS_RX_CTRL, 8'h92);
    rd(`USAT_OFS_RX_HOLD, 8'h44);
    rd(`USAT_OFS_RX_CTRL, 8'h92);
    wr(`USAT_OFS_RX_CTRL, 8'h80);
    rd(`USAT_OFS_RX_CTRL, 8'h80);
    $display("test receive done");
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`USAT_OFS_TX_CTRL, 8'h02);
    rd(`USAT_OFS_RX_CTRL, 8'h00);
    $display("test reset done");
    report_and_stop();
  end
endmodule // usart_async_tx_and_rx_status_test
